// *** shared/prs_pkg.sv ***
// package: constants and carriers for the pin-selected rail state block
package prs_pkg;
	// ----------------------------------------------------------------
	// block command layout
	// ----------------------------------------------------------------
	localparam logic [7:0] PRS_CMD_CODE = 8'hdd;
	localparam logic [7:0] PRS_BYTE_COUNT = 8'h22;
	localparam logic [5:0] PRS_IDX_COUNT = 6'h00;
	localparam logic [5:0] PRS_IDX_ENABLE = 6'h01;
	localparam logic [5:0] PRS_IDX_SOFT = 6'h02;
	localparam logic [5:0] PRS_IDX_MASK0 = 6'h03;
	localparam logic [5:0] PRS_IDX_LAST = 6'h22;
	localparam logic [5:0] PRS_IDX_MAX = 6'h3f;

	// ----------------------------------------------------------------
	// sizes, reset values and control word codes
	// ----------------------------------------------------------------
	localparam int PRS_NUM_STATES = 8;
	localparam int PRS_NUM_RAILS = 32;
	localparam logic [4:0] PRS_LAST_PAGE = 5'h1f;
	localparam logic [7:0] PRS_ENABLE_RST = 8'h00;
	localparam logic [7:0] PRS_SOFT_RST = 8'h00;
	localparam logic [31:0] PRS_MASK_RST = 32'h0000_0000;
	localparam logic [7:0] PRS_OP_ON = 8'h80;
	localparam logic [7:0] PRS_OP_OFF_HARD = 8'h00;
	localparam logic [7:0] PRS_OP_OFF_SOFT = 8'h40;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PRS_CLK_PERIOD_NS = 20;
	localparam int PRS_SETTLE_NS = 1000;
	localparam int PRS_SETTLE_CYC = (PRS_SETTLE_NS + PRS_CLK_PERIOD_NS - 1) / PRS_CLK_PERIOD_NS;
	localparam logic [5:0] PRS_SETTLE_LAST = 6'(PRS_SETTLE_CYC - 1);

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic start;
		logic [7:0] cmd_code;
		logic wr_valid;
		logic [7:0] wr_byte;
		logic rd_req;
	} prs_host_req_t;

	typedef struct packed {
		logic valid;
		logic [4:0] page;
		logic [7:0] value;
	} prs_op_wr_t;
endpackage

// *** core/prs_mask_mem.sv ***
// eight 32-bit state masks, byte-lane writes, two registered read ports
`timescale 1ns/10ps
`default_nettype none
module prs_mask_mem (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [3:0] wr_be,
	input wire logic [31:0] wr_data,
	input wire logic [2:0] a_addr,
	output logic [31:0] a_data,
	input wire logic [2:0] b_addr,
	output logic [31:0] b_data
);
	logic [31:0] mem_reg [prs_pkg::PRS_NUM_STATES];

	genvar w, l;
	generate
		for (w = 0; w < prs_pkg::PRS_NUM_STATES; w++) begin : g_word
			for (l = 0; l < 4; l++) begin : g_lane
				always_ff @(posedge clk_sys) begin
					if (!rst_b) begin
						mem_reg[w][8*l +: 8] <= prs_pkg::PRS_MASK_RST[8*l +: 8];
					end else if (wr_en && wr_addr == 3'(w) && wr_be[l]) begin
						mem_reg[w][8*l +: 8] <= wr_data[8*l +: 8];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			a_data <= prs_pkg::PRS_MASK_RST;
			b_data <= prs_pkg::PRS_MASK_RST;
		end else begin
			a_data <= mem_reg[a_addr];
			b_data <= mem_reg[b_addr];
		end
	end
endmodule
`default_nettype wire

// *** core/prs_core.sv ***
// pin-selected rail state controller: config block command and rail rewrite walk
// ----------------------------------------------------------------
// How it works
// [RQ1] three routed input pins act as the selector for one of eight system states.
// [RQ2] the state index is pin 2 as msb down to pin 0 as lsb, giving 0 to 7.
// [RQ3] the block command carries count 34, enable byte, soft-off byte, then eight lsb-first masks.
// [RQ4] bit n of the enable byte enables state n and only enabled states are acted on.
// [RQ5] bit n of the soft-off byte picks soft off (1) or immediate off (0) for state n.
// [RQ6] each rewrite is handed to the sequencer, which honours the rail's dependencies.
// [RQ7] the control word written is 0x80 for on, 0x00 for hard off and 0x40 for soft off.
// [RQ8] only rails whose on/off configuration obeys the control command are rewritten.
// [RQ9] after every reset the pins are sampled and an enabled state updates every rail that obeys the control command.
// [RQ10] the external selector logic finishes all pin changes within one microsecond.
// [RQ11] the configuration is read and written as block command dd with the same layout.
// [RQ12] mask bit n belongs to rail page n, 1 meaning on and 0 meaning off.
// [RQ13] a selected state whose enable bit is clear leaves every control word untouched.
// [RQ14] a new pin combination is acted on only once it has been stable.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module prs_core (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire prs_pkg::prs_host_req_t host_req,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic wr_err,
	input wire logic [2:0] sel_in,
	input wire logic [31:0] rail_uses_op,
	output prs_pkg::prs_op_wr_t op_wr,
	input wire logic op_wr_ready,
	output logic [2:0] active_state,
	output logic busy
);
	typedef enum logic [1:0] {PRS_IDLE, PRS_FETCH, PRS_PREP, PRS_ISSUE} prs_state_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// payload byte index to mask word and byte lane
	function automatic logic [4:0] prs_mask_pos(input logic [5:0] idx);
		logic [5:0] off;
		off = idx - prs_pkg::PRS_IDX_MASK0;
		prs_mask_pos = off[4:0];
	endfunction

	function automatic logic prs_is_mask(input logic [5:0] idx);
		prs_is_mask = idx >= prs_pkg::PRS_IDX_MASK0 && idx <= prs_pkg::PRS_IDX_LAST;
	endfunction

	logic [7:0] state_enable_bits_reg;
	logic [7:0] soft_off_select_bits_reg;
	logic sel_cmd_reg;
	logic count_ok_reg;
	logic [5:0] idx_reg;
	logic [5:0] rd_idx_reg;
	logic rd_pend_reg;
	logic [4:0] wr_pos;
	logic [4:0] rd_pos;
	logic [4:0] rd_pos_reg;
	logic mem_wr_en;
	logic [3:0] mem_wr_be;
	logic [31:0] a_data;
	logic [31:0] b_data;
	logic [2:0] b_addr;
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] cand_reg;
	logic [5:0] settle_cnt_reg;
	logic settled_reg;
	logic need_first_reg;
	logic [2:0] applied_sel_reg;
	prs_state_t state_reg;
	logic [31:0] mask_reg;
	logic soft_reg;
	logic [4:0] page_reg;
	logic start_apply;

	// ----------------------------------------------------------------
	// block command byte stream
	// ----------------------------------------------------------------
	assign wr_pos = prs_mask_pos(idx_reg);
	assign rd_pos = prs_mask_pos(idx_reg);
	assign mem_wr_en = sel_cmd_reg && host_req.wr_valid && count_ok_reg
		&& prs_is_mask(idx_reg); // [RQ3]
	assign mem_wr_be = 4'h1 << wr_pos[1:0]; // [RQ3]

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sel_cmd_reg <= 1'b0;
			idx_reg <= prs_pkg::PRS_IDX_COUNT;
		end else if (host_req.start) begin
			sel_cmd_reg <= host_req.cmd_code == prs_pkg::PRS_CMD_CODE; // [RQ11]
			idx_reg <= prs_pkg::PRS_IDX_COUNT;
		end else if (sel_cmd_reg && (host_req.wr_valid || host_req.rd_req)
			&& idx_reg != prs_pkg::PRS_IDX_MAX) begin
			idx_reg <= idx_reg + 6'h01;
		end
	end

	// a wrong count poisons the rest of the transfer; bytes already taken stay
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			count_ok_reg <= 1'b0;
			wr_err <= 1'b0;
		end else if (host_req.start) begin
			count_ok_reg <= 1'b0;
			wr_err <= 1'b0;
		end else if (sel_cmd_reg && host_req.wr_valid) begin
			if (idx_reg == prs_pkg::PRS_IDX_COUNT) begin
				count_ok_reg <= host_req.wr_byte == prs_pkg::PRS_BYTE_COUNT; // [RQ3]
				wr_err <= host_req.wr_byte != prs_pkg::PRS_BYTE_COUNT;
			end else if (idx_reg > prs_pkg::PRS_IDX_LAST) begin
				wr_err <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_enable_bits_reg <= prs_pkg::PRS_ENABLE_RST;
			soft_off_select_bits_reg <= prs_pkg::PRS_SOFT_RST;
		end else if (sel_cmd_reg && host_req.wr_valid && count_ok_reg) begin
			if (idx_reg == prs_pkg::PRS_IDX_ENABLE) begin
				state_enable_bits_reg <= host_req.wr_byte; // [RQ3]
			end
			if (idx_reg == prs_pkg::PRS_IDX_SOFT) begin
				soft_off_select_bits_reg <= host_req.wr_byte; // [RQ3]
			end
		end
	end

	// reads: two-stage pipe because the mask port is registered
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_pend_reg <= 1'b0;
			rd_idx_reg <= prs_pkg::PRS_IDX_COUNT;
			rd_pos_reg <= 5'h00;
		end else begin
			rd_pend_reg <= sel_cmd_reg && host_req.rd_req && !host_req.start;
			rd_idx_reg <= idx_reg;
			rd_pos_reg <= rd_pos;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			rd_valid <= rd_pend_reg; // [RQ11]
			if (rd_idx_reg == prs_pkg::PRS_IDX_COUNT) begin
				rd_data <= prs_pkg::PRS_BYTE_COUNT;
			end else if (rd_idx_reg == prs_pkg::PRS_IDX_ENABLE) begin
				rd_data <= state_enable_bits_reg;
			end else if (rd_idx_reg == prs_pkg::PRS_IDX_SOFT) begin
				rd_data <= soft_off_select_bits_reg;
			end else if (prs_is_mask(rd_idx_reg)) begin
				rd_data <= a_data[8*rd_pos_reg[1:0] +: 8]; // [RQ11]
			end else begin
				rd_data <= 8'h00;
			end
		end
	end

	prs_mask_mem u_mem (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.wr_en(mem_wr_en),
		.wr_addr(wr_pos[4:2]),
		.wr_be(mem_wr_be),
		.wr_data({4{host_req.wr_byte}}),
		.a_addr(rd_pos[4:2]),
		.a_data(a_data),
		.b_addr(b_addr),
		.b_data(b_data)
	);

	// ----------------------------------------------------------------
	// selector pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= sel_in; // [RQ1]
			sync2_reg <= sync1_reg;
		end
	end

	// settle window covers the allowed pin skew so one selection gives one update
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cand_reg <= 3'h0;
			settle_cnt_reg <= 6'h00;
			settled_reg <= 1'b0;
		end else if (sync2_reg != cand_reg) begin
			cand_reg <= sync2_reg; // [RQ2]
			settle_cnt_reg <= 6'h00; // [RQ14]
			settled_reg <= 1'b0;
		end else if (settle_cnt_reg == prs_pkg::PRS_SETTLE_LAST) begin
			settled_reg <= 1'b1; // [RQ10]
		end else begin
			settle_cnt_reg <= settle_cnt_reg + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// rail rewrite walk
	// ----------------------------------------------------------------
	assign start_apply = state_reg == PRS_IDLE && settled_reg
		&& (need_first_reg || cand_reg != applied_sel_reg); // [RQ14]
	assign b_addr = state_reg == PRS_IDLE ? cand_reg : applied_sel_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			need_first_reg <= 1'b1; // [RQ9]
			applied_sel_reg <= 3'h0;
		end else if (start_apply) begin
			need_first_reg <= 1'b0;
			applied_sel_reg <= cand_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_reg <= PRS_IDLE;
			page_reg <= 5'h00;
			mask_reg <= prs_pkg::PRS_MASK_RST;
			soft_reg <= 1'b0;
			op_wr <= '0;
		end else begin
			case (state_reg)
				PRS_IDLE: begin
					// disabled selection is consumed with no rewrite
					if (start_apply && state_enable_bits_reg[cand_reg]) begin // [RQ4] [RQ13]
						state_reg <= PRS_FETCH;
					end
				end
				PRS_FETCH: begin
					mask_reg <= b_data; // [RQ12]
					soft_reg <= soft_off_select_bits_reg[applied_sel_reg]; // [RQ5]
					page_reg <= 5'h00;
					state_reg <= PRS_PREP;
				end
				PRS_PREP: begin
					if (rail_uses_op[page_reg]) begin // [RQ8]
						op_wr.valid <= 1'b1;
						op_wr.page <= page_reg;
						if (mask_reg[page_reg]) begin // [RQ12]
							op_wr.value <= prs_pkg::PRS_OP_ON; // [RQ7]
						end else if (soft_reg) begin
							op_wr.value <= prs_pkg::PRS_OP_OFF_SOFT; // [RQ7]
						end else begin
							op_wr.value <= prs_pkg::PRS_OP_OFF_HARD; // [RQ7]
						end
						state_reg <= PRS_ISSUE;
					end else if (page_reg == prs_pkg::PRS_LAST_PAGE) begin
						state_reg <= PRS_IDLE;
					end else begin
						page_reg <= page_reg + 5'h01;
					end
				end
				PRS_ISSUE: begin
					// the sequencer stalls us until it owns the change
					if (op_wr_ready) begin // [RQ6]
						op_wr.valid <= 1'b0;
						if (page_reg == prs_pkg::PRS_LAST_PAGE) begin
							state_reg <= PRS_IDLE;
						end else begin
							page_reg <= page_reg + 5'h01;
							state_reg <= PRS_PREP;
						end
					end
				end
				default: begin
					state_reg <= PRS_IDLE;
					op_wr.valid <= 1'b0;
				end
			endcase
		end
	end

	assign active_state = applied_sel_reg;
	assign busy = state_reg != PRS_IDLE;
endmodule
`default_nettype wire

// *** verification/prs_core_asserts.sv ***
// checker: timing and encoding relations at the rail state controller ports
`timescale 1ns/10ps
`default_nettype none
module prs_core_asserts (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire prs_pkg::prs_host_req_t host_req,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic wr_err,
	input wire logic [2:0] sel_in,
	input wire logic [31:0] rail_uses_op,
	input wire prs_pkg::prs_op_wr_t op_wr,
	input wire logic op_wr_ready,
	input wire logic [2:0] active_state,
	input wire logic busy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// reads are only answered inside a transfer that chose this block
	logic dd_reg;
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			dd_reg <= 1'b0;
		else if (host_req.start)
			dd_reg <= (host_req.cmd_code == prs_pkg::PRS_CMD_CODE);
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_word; op_wr.valid |-> op_wr.value inside {8'h80, 8'h00, 8'h40}; endproperty
	a_word: assert property (p_word) else $error("bad control word");
	property p_gate; op_wr.valid |-> rail_uses_op[op_wr.page]; endproperty
	a_gate: assert property (p_gate) else $error("rewrite of ignoring rail");
	property p_hold; op_wr.valid && !op_wr_ready |=> op_wr.valid && $stable(op_wr); endproperty
	a_hold: assert property (p_hold) else $error("rewrite dropped early");
	property p_gap; op_wr.valid && op_wr_ready |=> !op_wr.valid; endproperty
	a_gap: assert property (p_gap) else $error("rewrite gap too short");
	property p_walk; $rose(busy) |-> ##[1:400] !busy; endproperty
	a_walk: assert property (p_walk) else $error("walk never ends");
	property p_sel; $changed(active_state) |-> active_state == $past(sel_in, 3); endproperty
	a_sel: assert property (p_sel) else $error("state not from pins");
	property p_settle; $changed(active_state) |-> active_state == $past(sel_in, 45); endproperty
	a_settle: assert property (p_settle) else $error("pins not stable");
	property p_rd; host_req.rd_req && !host_req.start && dd_reg |-> ##2 rd_valid; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_cnt;
		host_req.start && host_req.cmd_code == 8'hdd ##1
		host_req.wr_valid && !host_req.start && host_req.wr_byte != 8'h22 |=> wr_err;
	endproperty
	a_cnt: assert property (p_cnt) else $error("bad count accepted");
	property p_clr; host_req.start |=> !wr_err; endproperty
	a_clr: assert property (p_clr) else $error("error flag kept");
endmodule
bind prs_core prs_core_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .host_req(host_req),
	.rd_data(rd_data), .rd_valid(rd_valid), .wr_err(wr_err), .sel_in(sel_in),
	.rail_uses_op(rail_uses_op), .op_wr(op_wr), .op_wr_ready(op_wr_ready),
	.active_state(active_state), .busy(busy));
`default_nettype wire

// *** verification/prs_seq_model.sv ***
// model: rail sequencer taking control word rewrites after a chosen lag
`timescale 1ns/10ps
`default_nettype none
module prs_seq_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire prs_pkg::prs_op_wr_t op_wr,
	input wire logic [1:0] lag,
	output logic op_wr_ready,
	output logic [31:0][7:0] ctl_word,
	output logic [7:0] n_wr
);
	logic [1:0] wait_reg;
	// ----------------------------------------------------------------
	// accept
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			op_wr_ready <= 1'b0;
			wait_reg <= 2'h0;
		end else if (op_wr.valid && !op_wr_ready && wait_reg == lag) begin
			op_wr_ready <= 1'b1;
			wait_reg <= 2'h0;
		end else begin
			op_wr_ready <= 1'b0;
			wait_reg <= (op_wr.valid && !op_wr_ready) ? wait_reg + 2'h1 : 2'h0;
		end
	end
	// words survive a controller reset, as the rails keep running
	initial begin
		ctl_word = {32{8'h11}};
		n_wr = 8'h00;
	end
	always @(posedge clk_sys) begin
		if (op_wr.valid && op_wr_ready) begin
			ctl_word[op_wr.page] <= op_wr.value;
			n_wr <= n_wr + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: host config, pin-selected states and rail rewrites
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct packed {logic [2:0] sel; logic [7:0] n_exp;} prs_row_t;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	prs_pkg::prs_host_req_t host_req = '0;
	logic [2:0] sel_in = 3'h0;
	logic [31:0] rail_uses_op = 32'hf0f0_ff0f;
	logic [1:0] lag = 2'h0;
	logic [7:0] rd_data, n_wr, n0;
	logic rd_valid, wr_err, op_wr_ready, busy;
	logic [2:0] active_state;
	prs_pkg::prs_op_wr_t op_wr;
	logic [31:0][7:0] ctl_word, exp_ctl;
	logic [7:0] cfg [36];
	logic [31:0] mask [8];
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	prs_row_t rows [8] = '{'{3'h5, 8'h14}, '{3'h2, 8'h14}, '{3'h7, 8'h14}, '{3'h3, 8'h00},
		'{3'h0, 8'h14}, '{3'h6, 8'h00}, '{3'h1, 8'h14}, '{3'h4, 8'h14}};
	prs_core DUT (.clk_sys(clk_sys), .rst_b(rst_b), .host_req(host_req), .rd_data(rd_data),
		.rd_valid(rd_valid), .wr_err(wr_err), .sel_in(sel_in), .rail_uses_op(rail_uses_op),
		.op_wr(op_wr), .op_wr_ready(op_wr_ready), .active_state(active_state), .busy(busy));
	prs_seq_model u_seq (.clk_sys(clk_sys), .rst_b(rst_b), .op_wr(op_wr), .lag(lag),
		.op_wr_ready(op_wr_ready), .ctl_word(ctl_word), .n_wr(n_wr));
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("mismatches=%0d checks=%0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic drv(input logic s, input logic [7:0] c, input logic w, input logic [7:0] b,
		input logic r);
		@(posedge clk_sys);
		host_req <= {s, c, w, b, r};
	endtask
	// n bytes written from cfg, or n read back and compared against cfg
	task automatic xfer(input logic [7:0] cmd, input int n, input logic rd);
		int j;
		j = 0;
		drv(1'b1, cmd, 1'b0, 8'h00, 1'b0);
		for (int i = 0; i < n + 3; i++) begin
			drv(1'b0, cmd, !rd && i < n, cfg[i % 36], rd && i < n);
			#1;
			if (rd_valid === 1'b1) begin
				chk(rd_data, cfg[j]);
				j++;
			end
		end
		if (rd)
			chk(j, cmd == 8'hdd ? n : 0);
	endtask
	task automatic reset_pulse();
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk({busy, rd_valid, wr_err, op_wr.valid, active_state}, 0);
		@(posedge clk_sys);
		rst_b <= 1'b1;
	endtask
	task automatic check_state(input logic [2:0] s, input logic [7:0] n_old, input logic [7:0] n_exp);
		for (int i = 0; i < 400 && (active_state !== s || busy !== 1'b0); i++) begin
			@(posedge clk_sys);
			#1;
		end
		chk(active_state, s);
		chk(8'(n_wr - n_old), n_exp);
		for (int p = 0; p < 32; p++) begin
			if (cfg[1][s] && rail_uses_op[p])
				exp_ctl[p] = mask[s][p] ? 8'h80 : (cfg[2][s] ? 8'h40 : 8'h00);
			chk(ctl_word[p], exp_ctl[p]);
		end
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		exp_ctl = {32{8'h11}};
		cfg[0] = 8'h21;
		cfg[1] = 8'hb7;
		cfg[2] = 8'h5a;
		for (int s = 0; s < 8; s++) begin
			mask[s] = 32'ha5c3_0f96 ^ (s * 32'h1357_9bd1);
			for (int b = 0; b < 4; b++)
				cfg[3 + 4 * s + b] = mask[s][8 * b +: 8];
		end
		cfg[35] = 8'h00;
		reset_pulse();
		xfer(8'hdd, 2, 1'b0);
		chk(wr_err, 1'b1);
		cfg[0] = 8'h22;
		xfer(8'hdd, 36, 1'b0);
		chk(wr_err, 1'b1);
		xfer(8'hdd, 35, 1'b0);
		chk(wr_err, 1'b0);
		xfer(8'hdd, 36, 1'b1);
		xfer(8'hd5, 3, 1'b1);
		// the apply that follows reset runs during the config transfers; let it finish first
		check_state(3'h0, 8'h00, 8'h14);
		for (int r = 0; r < 8; r++) begin
			@(posedge clk_sys);
			lag <= rows[r].sel[1:0];
			sel_in <= rows[r].sel;
			check_state(rows[r].sel, n_wr, rows[r].n_exp);
		end
		// a pin change during a walk waits for that walk to finish
		@(posedge clk_sys);
		sel_in <= 3'h7;
		n0 = n_wr;
		repeat (60) @(posedge clk_sys);
		#1;
		chk(busy, 1'b1);
		@(posedge clk_sys);
		sel_in <= 3'h1;
		check_state(3'h1, n0, 8'h28);
		for (int i = 1; i < 36; i++)
			cfg[i] = 8'h00;
		reset_pulse();
		check_state(3'h1, n_wr, 8'h00);
		xfer(8'hdd, 35, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
